// ==== design/bvr_pkg.sv ====
// Package of constants, types and states for the background variable read copier
//==========================================================================
package bvr_pkg;
   //==========================================================================
   // Header offsets in host bytes, shared memory is 16-bit words
   localparam logic [15:0] BVR_CTRL_OFS = 16'h07e8;
   localparam logic [15:0] BVR_TIMER_OFS = 16'h07ea;
   localparam logic [15:0] BVR_SIZE_OFS = 16'h07ec;
   localparam logic [15:0] BVR_START_OFS = 16'h07ee;
   // Internal address of shared memory word pair zero
   localparam logic [15:0] BVR_SHARED_BASE = 16'hd000;
   // Internal register that holds the function block base address
   localparam logic [15:0] BVR_FCB_BASE_ADDR = 16'h9fff;
   localparam logic [15:0] BVR_MAX_ENTRIES = 16'h0080;
   //==========================================================================
   // Field positions
   localparam int BVR_RDY_BIT = 15;
   localparam int BVR_MODE_BIT = 8;
   localparam int BVR_DONE_BIT = 0;
   // Type codes
   localparam logic [2:0] BVR_T_Y = 3'h0;
   localparam logic [2:0] BVR_T_LONG = 3'h1;
   localparam logic [2:0] BVR_T_X = 3'h2;
   localparam logic [2:0] BVR_T_SPECIAL = 3'h4;
   // Counts
   localparam logic [1:0] BVR_RD_LAT = 2'h2;
   localparam int BVR_FIFO_DEPTH = 16;
   localparam int BVR_WR_WIDTH = 29;
   //==========================================================================
   // Internal register spaces
   typedef enum logic [1:0] {
      BVR_SP_Y = 2'b00,
      BVR_SP_LONG = 2'b01,
      BVR_SP_X = 2'b10
   } bvr_space_type;
   typedef enum logic [3:0] {
      BVR_S_IDLE = 4'b0000,
      BVR_S_SIZE = 4'b0001,
      BVR_S_START = 4'b0010,
      BVR_S_CTRL = 4'b0011,
      BVR_S_ADDR = 4'b0100,
      BVR_S_TYPE = 4'b0101,
      BVR_S_BASE = 4'b0110,
      BVR_S_VAL = 4'b0111,
      BVR_S_PUSH = 4'b1000,
      BVR_S_FLAG = 4'b1001,
      BVR_S_NEXT = 4'b1010,
      BVR_S_TIMER = 4'b1011,
      BVR_S_CSET = 4'b1100
   } bvr_state_type;
   //==========================================================================
   // Carriers
   typedef struct packed {
      logic en;
      logic we;
      logic [12:0] addr;
      logic [15:0] wdata;
   } bvr_ram_req_type;
   typedef struct packed {
      logic valid;
      bvr_space_type space;
      logic [15:0] addr;
   } bvr_reg_req_type;
   typedef struct packed {
      logic [12:0] addr;
      logic [15:0] data;
   } bvr_wr_type;
endpackage

// ==== design/bvr_sext.sv ====
// Sign extension of one 24-bit register half to 32 bits
`timescale 1ns/1ps
module bvr_sext (
   input wire logic [23:0] value,
   output logic [31:0] ext
);
   // Replicate the sign bit
   assign ext = {{8{value[23]}}, value};
endmodule

// ==== design/bvr_fifo.sv ====
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module bvr_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // Flags from the fill count
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   // Storage
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   // Pointers and count
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ==== design/bvr_copier.sv ====
// Background variable read copier: internal registers into shared memory
`timescale 1ns/1ps
module bvr_copier (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic background_buffer_enable_param,
   input wire logic bg_cycle,
   input wire logic [15:0] servo_timer,
   output bvr_pkg::bvr_ram_req_type ram_req,
   input wire logic [15:0] ram_rdata,
   output bvr_pkg::bvr_reg_req_type reg_req,
   input wire logic reg_ack,
   input wire logic [47:0] reg_data,
   output logic busy,
   output logic pass_done
);
   //==========================================================================
   // State and captured header
   bvr_pkg::bvr_state_type state;
   bvr_pkg::bvr_state_type next_state;
   bvr_pkg::bvr_ram_req_type next_ram;
   logic [1:0] cnt;
   logic [7:0] size_q;
   logic [15:0] start_q;
   logic [15:0] ctrl_q;
   logic [15:0] addr_q;
   logic [15:0] type_q;
   logic [15:0] base_q;
   logic [47:0] val_q;
   logic [7:0] idx;
   logic [12:0] ptr;
   logic [1:0] k;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   bvr_pkg::bvr_wr_type fifo_in;
   bvr_pkg::bvr_wr_type fifo_out;
   logic [31:0] lo32;
   logic [31:0] hi32;
   //==========================================================================
   // Address decode
   wire multi = ctrl_q[bvr_pkg::BVR_MODE_BIT];
   wire [15:0] start_rel = start_q - bvr_pkg::BVR_SHARED_BASE;
   wire [12:0] ent_base = {start_rel[11:0], 1'b0};
   wire [12:0] ent_addr_w = ent_base + {4'h0, idx, 1'b0};
   wire [12:0] ent_type_w = ent_addr_w + 13'h0001;
   wire [12:0] data_base_w = ent_base + {4'h0, size_q, 1'b0};
   wire [12:0] ctrl_w = bvr_pkg::BVR_CTRL_OFS[13:1];
   wire [12:0] timer_w = bvr_pkg::BVR_TIMER_OFS[13:1];
   wire [12:0] size_w = bvr_pkg::BVR_SIZE_OFS[13:1];
   wire [12:0] start_w = bvr_pkg::BVR_START_OFS[13:1];
   //==========================================================================
   // Shared memory read sequencing
   wire rd_state = (state == bvr_pkg::BVR_S_SIZE) || (state == bvr_pkg::BVR_S_START) ||
                   (state == bvr_pkg::BVR_S_CTRL) || (state == bvr_pkg::BVR_S_ADDR) ||
                   (state == bvr_pkg::BVR_S_TYPE);
   wire rd_issue = rd_state && (cnt == 2'h0);
   wire rd_cap = rd_state && (cnt == 2'h1);
   wire [12:0] rd_addr = (state == bvr_pkg::BVR_S_SIZE) ? size_w :
                         (state == bvr_pkg::BVR_S_START) ? start_w :
                         (state == bvr_pkg::BVR_S_CTRL) ? ctrl_w :
                         (state == bvr_pkg::BVR_S_ADDR) ? ent_addr_w : ent_type_w;
   //==========================================================================
   // Entry type decode
   wire [2:0] tcode = type_q[2:0];
   wire is_special = (tcode == bvr_pkg::BVR_T_SPECIAL);
   wire is_long = (tcode == bvr_pkg::BVR_T_LONG) || is_special;
   wire [12:0] len_w = is_long ? 13'h0004 : 13'h0002;
   wire [1:0] last_k = is_long ? 2'h3 : 2'h1;
   wire rd_skip = multi && ram_rdata[bvr_pkg::BVR_RDY_BIT];
   wire [15:0] size_clamp = (ram_rdata > bvr_pkg::BVR_MAX_ENTRIES) ?
                            bvr_pkg::BVR_MAX_ENTRIES : ram_rdata;
   //==========================================================================
   // Internal register request
   wire [15:0] fcb_addr = base_q + addr_q;
   assign reg_req.valid = (state == bvr_pkg::BVR_S_BASE) || (state == bvr_pkg::BVR_S_VAL);
   assign reg_req.addr = (state == bvr_pkg::BVR_S_BASE) ? bvr_pkg::BVR_FCB_BASE_ADDR :
                         is_special ? fcb_addr : addr_q;
   assign reg_req.space = (state == bvr_pkg::BVR_S_BASE) ? bvr_pkg::BVR_SP_Y :
                          is_long ? bvr_pkg::BVR_SP_LONG :
                          (tcode == bvr_pkg::BVR_T_X) ? bvr_pkg::BVR_SP_X : bvr_pkg::BVR_SP_Y;
   //==========================================================================
   // Value formatting and write commands
   bvr_sext u_sext_lo (
      .value(val_q[23:0]),
      .ext(lo32)
   );
   bvr_sext u_sext_hi (
      .value(val_q[47:24]),
      .ext(hi32)
   );
   wire [15:0] push_word = (k == 2'h0) ? lo32[15:0] :
                           (k == 2'h1) ? lo32[31:16] :
                           (k == 2'h2) ? hi32[15:0] : hi32[31:16];
   wire [15:0] flag_word = type_q | 16'h8000;
   wire [15:0] done_word = ctrl_q | 16'h0001;
   assign fifo_in_valid = (state == bvr_pkg::BVR_S_PUSH) || (state == bvr_pkg::BVR_S_FLAG) ||
                          (state == bvr_pkg::BVR_S_TIMER) || (state == bvr_pkg::BVR_S_CSET);
   assign fifo_in.addr = (state == bvr_pkg::BVR_S_PUSH) ? ptr + {11'h000, k} :
                         (state == bvr_pkg::BVR_S_FLAG) ? ent_type_w :
                         (state == bvr_pkg::BVR_S_TIMER) ? timer_w : ctrl_w;
   assign fifo_in.data = (state == bvr_pkg::BVR_S_PUSH) ? push_word :
                         (state == bvr_pkg::BVR_S_FLAG) ? flag_word :
                         (state == bvr_pkg::BVR_S_TIMER) ? servo_timer : done_word;
   wire pushed = fifo_in_valid && fifo_in_ready;
   // Write drain stalls only in the cycle the engine issues a memory read
   assign fifo_out_ready = !rd_issue;
   bvr_fifo #(
      .WIDTH(bvr_pkg::BVR_WR_WIDTH),
      .DEPTH(bvr_pkg::BVR_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );
   //==========================================================================
   // Memory port selection, engine reads first
   always_comb begin
      next_ram = '0;
      if (rd_issue) begin
         next_ram.en = 1'b1;
         next_ram.addr = rd_addr;
      end else if (fifo_out_valid) begin
         next_ram.en = 1'b1;
         next_ram.we = 1'b1;
         next_ram.addr = fifo_out.addr;
         next_ram.wdata = fifo_out.data;
      end
   end
   //==========================================================================
   // Next state
   always_comb begin
      next_state = state;
      case (state)
         bvr_pkg::BVR_S_IDLE: begin
            if (bg_cycle && background_buffer_enable_param && !fifo_out_valid) begin
               next_state = bvr_pkg::BVR_S_SIZE;
            end
         end
         bvr_pkg::BVR_S_SIZE: begin
            if (rd_cap) begin
               next_state = (ram_rdata == 16'h0000) ? bvr_pkg::BVR_S_IDLE :
                            bvr_pkg::BVR_S_START;
            end
         end
         bvr_pkg::BVR_S_START: begin
            if (rd_cap) begin
               next_state = bvr_pkg::BVR_S_CTRL;
            end
         end
         bvr_pkg::BVR_S_CTRL: begin
            if (rd_cap) begin
               next_state = (!ram_rdata[bvr_pkg::BVR_MODE_BIT] &&
                             ram_rdata[bvr_pkg::BVR_DONE_BIT]) ?
                            bvr_pkg::BVR_S_IDLE : bvr_pkg::BVR_S_ADDR;
            end
         end
         bvr_pkg::BVR_S_ADDR: begin
            if (rd_cap) begin
               next_state = bvr_pkg::BVR_S_TYPE;
            end
         end
         bvr_pkg::BVR_S_TYPE: begin
            if (rd_cap) begin
               if (rd_skip) begin
                  next_state = bvr_pkg::BVR_S_NEXT;
               end else if (ram_rdata[2:0] == bvr_pkg::BVR_T_SPECIAL) begin
                  next_state = bvr_pkg::BVR_S_BASE;
               end else begin
                  next_state = bvr_pkg::BVR_S_VAL;
               end
            end
         end
         bvr_pkg::BVR_S_BASE: begin
            if (reg_ack) begin
               next_state = bvr_pkg::BVR_S_VAL;
            end
         end
         bvr_pkg::BVR_S_VAL: begin
            if (reg_ack) begin
               next_state = bvr_pkg::BVR_S_PUSH;
            end
         end
         bvr_pkg::BVR_S_PUSH: begin
            if (pushed && (k == last_k)) begin
               next_state = multi ? bvr_pkg::BVR_S_FLAG : bvr_pkg::BVR_S_NEXT;
            end
         end
         bvr_pkg::BVR_S_FLAG: begin
            if (pushed) begin
               next_state = bvr_pkg::BVR_S_NEXT;
            end
         end
         bvr_pkg::BVR_S_NEXT: begin
            next_state = (idx == size_q - 8'h01) ? bvr_pkg::BVR_S_TIMER : bvr_pkg::BVR_S_ADDR;
         end
         bvr_pkg::BVR_S_TIMER: begin
            if (pushed) begin
               next_state = multi ? bvr_pkg::BVR_S_IDLE :
                            bvr_pkg::BVR_S_CSET;
            end
         end
         bvr_pkg::BVR_S_CSET: begin
            if (pushed) begin
               next_state = bvr_pkg::BVR_S_IDLE;
            end
         end
         default: begin
            next_state = bvr_pkg::BVR_S_IDLE;
         end
      endcase
   end
   //==========================================================================
   // State, read latency counter and memory port register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= bvr_pkg::BVR_S_IDLE;
         cnt <= 2'h0;
         ram_req <= '0;
      end else begin
         state <= next_state;
         cnt <= rd_issue ? bvr_pkg::BVR_RD_LAT : (cnt != 2'h0) ? cnt - 2'h1 : 2'h0;
         ram_req <= next_ram;
      end
   end
   // Header and entry captures
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         size_q <= 8'h00;
         start_q <= 16'h0000;
         ctrl_q <= 16'h0000;
         addr_q <= 16'h0000;
         type_q <= 16'h0000;
      end else if (rd_cap) begin
         case (state)
            bvr_pkg::BVR_S_SIZE: size_q <= size_clamp[7:0];
            bvr_pkg::BVR_S_START: start_q <= ram_rdata;
            bvr_pkg::BVR_S_CTRL: ctrl_q <= ram_rdata;
            bvr_pkg::BVR_S_ADDR: addr_q <= ram_rdata;
            default: type_q <= ram_rdata;
         endcase
      end
   end
   // Register answers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         base_q <= 16'h0000;
         val_q <= 48'h000000000000;
      end else if (reg_ack && (state == bvr_pkg::BVR_S_BASE)) begin
         base_q <= reg_data[15:0];
      end else if (reg_ack && (state == bvr_pkg::BVR_S_VAL)) begin
         val_q <= reg_data;
      end
   end
   // Entry index, data pointer and word counter
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         idx <= 8'h00;
         ptr <= 13'h0000;
         k <= 2'h0;
      end else begin
         if (rd_cap && (state == bvr_pkg::BVR_S_CTRL)) begin
            idx <= 8'h00;
            ptr <= data_base_w;
         end else if (state == bvr_pkg::BVR_S_NEXT) begin
            idx <= idx + 8'h01;
            ptr <= ptr + len_w;
         end
         k <= (state != bvr_pkg::BVR_S_PUSH) ? 2'h0 : pushed ? k + 2'h1 : k;
      end
   end
   // Status outputs
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         pass_done <= 1'b0;
      end else begin
         busy <= (next_state != bvr_pkg::BVR_S_IDLE) || fifo_out_valid;
         pass_done <= pushed && ((state == bvr_pkg::BVR_S_CSET) ||
                      ((state == bvr_pkg::BVR_S_TIMER) && multi));
      end
   end
   //==========================================================================
   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence timer_push_s;
      pushed && (state == bvr_pkg::BVR_S_TIMER) && !multi;
   endsequence
   sequence ctrl_set_s;
      ##[1:20] (pushed && (state == bvr_pkg::BVR_S_CSET) && fifo_in.data[0]);
   endsequence
   ctrl_untouched_a: assert property (pushed && (fifo_in.addr == ctrl_w) |-> !multi)
      else $error("control word written in multi user mode");
   size_zero_a: assert property (rd_cap && (state == bvr_pkg::BVR_S_SIZE) &&
      (ram_rdata == 16'h0000) |=> (state == bvr_pkg::BVR_S_IDLE))
      else $error("pass started with zero size");
   busy_skip_a: assert property (rd_cap && (state == bvr_pkg::BVR_S_CTRL) && !ram_rdata[8] &&
      ram_rdata[0] |=> (state == bvr_pkg::BVR_S_IDLE) && !busy)
      else $error("copy ran while data ready bit set");
   timer_value_a: assert property (pushed && (state == bvr_pkg::BVR_S_TIMER) |->
      (fifo_in.data == servo_timer) && (fifo_in.addr == 13'h03f5))
      else $error("timer snapshot wrong");
   done_after_timer_a: assert property (timer_push_s |-> ctrl_set_s)
      else $error("data ready not set after pass");
   sign_ext_a: assert property (pushed && (state == bvr_pkg::BVR_S_PUSH) && (k == 2'h1) |->
      (fifo_in.data == {{8{val_q[23]}}, val_q[23:16]}))
      else $error("upper word not sign extended");
   ready_flag_a: assert property (pushed && (state == bvr_pkg::BVR_S_FLAG) |->
      fifo_in.data[15] && multi && (fifo_in.addr == ent_type_w) &&
      ($past(state) != bvr_pkg::BVR_S_TYPE))
      else $error("ready flag write wrong");
   ready_skip_a: assert property (rd_cap && (state == bvr_pkg::BVR_S_TYPE) && rd_skip |=>
      (state == bvr_pkg::BVR_S_NEXT) && !reg_req.valid)
      else $error("ready entry was refreshed");
   block_base_a: assert property ((state == bvr_pkg::BVR_S_BASE) |->
      reg_req.valid && (reg_req.addr == 16'h9fff))
      else $error("block base not fetched first");
   multi_timer_a: assert property (pushed && (state == bvr_pkg::BVR_S_TIMER) && multi |=>
      pass_done && (state == bvr_pkg::BVR_S_IDLE))
      else $error("multi user pass end wrong");
   req_hold_a: assert property (reg_req.valid && !reg_ack |=>
      reg_req.valid && $stable(reg_req.addr))
      else $error("register request dropped");
endmodule

// ==== sim/bvr_host_model.sv ====
// Host side model: shared memory far port and internal register answers
`timescale 1ns/1ps
module bvr_host_model (
   input wire logic ref_clk,
   input wire logic slow,
   input wire bvr_pkg::bvr_ram_req_type ram_req,
   output logic [15:0] ram_rdata,
   input wire bvr_pkg::bvr_reg_req_type reg_req,
   output logic reg_ack,
   output logic [47:0] reg_data
);
   logic [15:0] mem [0:8191];
   logic [2:0] wait_cnt;
   logic [47:0] answer;
   //==========================================================================
   // Start values
   initial begin
      ram_rdata = 16'h0f0f;
      reg_ack = 1'b0;
      reg_data = 48'h0f0f0f0f0f0f;
      wait_cnt = 3'h0;
   end
   // Sync memory, read data scrambled outside its one cycle
   always @(posedge ref_clk) begin
      if (ram_req.en && ram_req.we) begin
         mem[ram_req.addr] <= ram_req.wdata;
      end
      if (ram_req.en && !ram_req.we) begin
         ram_rdata <= mem[ram_req.addr];
      end else begin
         ram_rdata <= ~ram_rdata;
      end
   end
   // Register contents; block base word holds 0x1000
   assign answer = (reg_req.addr == 16'h9fff && reg_req.space == bvr_pkg::BVR_SP_Y) ?
      48'h000000001000 :
      (reg_req.space == bvr_pkg::BVR_SP_X) ? {24'h000000, ~reg_req.addr, 8'ha5} :
      {~reg_req.addr, 8'ha5, reg_req.addr, 8'h5a};
   // Answer promptly or after five cycles, one-cycle pulse
   always @(posedge ref_clk) begin
      if (reg_req.valid && !reg_ack && wait_cnt >= (slow ? 3'h5 : 3'h0)) begin
         reg_ack <= 1'b1;
         reg_data <= answer;
         wait_cnt <= 3'h0;
      end else begin
         reg_ack <= 1'b0;
         reg_data <= ~reg_data;
         wait_cnt <= reg_req.valid ? wait_cnt + 3'h1 : 3'h0;
      end
   end
endmodule

// ==== sim/test_background_variable_read_copier.sv ====
// Self-checking bench for the background variable read copier
`timescale 1ns/1ps
module test_background_variable_read_copier;
   logic ref_clk, resetn, en, bg_cycle, slow, busy, pass_done, reg_ack, seen_done;
   logic [15:0] servo_timer, ram_rdata;
   logic [47:0] reg_data;
   logic [15:0] exp_q[$];
   bvr_pkg::bvr_ram_req_type ram_req;
   bvr_pkg::bvr_reg_req_type reg_req;
   int err_count, n_compared;
   //==========================================================================
   // Design and host side
   bvr_copier uut (.ref_clk(ref_clk), .resetn(resetn), .background_buffer_enable_param(en),
      .bg_cycle(bg_cycle), .servo_timer(servo_timer), .ram_req(ram_req),
      .ram_rdata(ram_rdata), .reg_req(reg_req), .reg_ack(reg_ack), .reg_data(reg_data),
      .busy(busy), .pass_done(pass_done));
   bvr_host_model host (.ref_clk(ref_clk), .slow(slow), .ram_req(ram_req),
      .ram_rdata(ram_rdata), .reg_req(reg_req), .reg_ack(reg_ack), .reg_data(reg_data));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Catch the one-cycle completion pulse
   always @(posedge ref_clk) begin
      if (pass_done === 1'b1) begin
         seen_done <= 1'b1;
      end
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Two expected words of a sign-extended 24-bit value
   task automatic push_sx(input logic [23:0] v);
      exp_q.push_back(v[15:0]);
      exp_q.push_back({{8{v[23]}}, v[23:16]});
   endtask
   // Start a background cycle; wait for completion or a quiet spell
   task automatic run_pass(input logic want);
      int n;
      seen_done = 1'b0;
      bg_cycle = 1'b1;
      step(1);
      bg_cycle = 1'b0;
      n = want ? 3000 : 300;
      while (n > 0 && !(want && seen_done === 1'b1 && busy === 1'b0)) begin
         step(1);
         n--;
      end
      if (want && n == 0) begin
         err_count++;
         tally_and_finish();
      end
      check("pass done", {15'h0000, seen_done}, {15'h0000, want});
      check("idle", {15'h0000, busy}, 16'h0000);
   endtask
   task automatic single_user();
      logic [15:0] ent[8] = '{16'h8001, 0, 16'h0040, 1, 16'h0002, 2, 16'h0003, 4};
      host.mem[16'h3f4] = 16'h0000;
      host.mem[16'h3f6] = 16'h0004;
      host.mem[16'h3f7] = 16'hd200;
      for (int i = 0; i < 8; i++) host.mem[16'h400 + i] = ent[i];
      push_sx({16'h8001, 8'h5a});
      push_sx({16'h0040, 8'h5a});
      push_sx({16'hffbf, 8'ha5});
      push_sx({16'hfffd, 8'ha5});
      push_sx({16'h1003, 8'h5a});
      push_sx({16'heffc, 8'ha5});
      run_pass(1'b1);
      for (int i = 0; i < 12; i++) check("data", host.mem[16'h408 + i], exp_q[i]);
      check("timer", host.mem[16'h3f5], 16'h1234);
      check("control", host.mem[16'h3f4], 16'h0001);
      host.mem[16'h408] = 16'hdead;
      servo_timer = 16'h5678;
      run_pass(1'b0);
      check("skipped", host.mem[16'h408], 16'hdead);
      host.mem[16'h3f4] = 16'h0000;
      slow = 1'b0;
      run_pass(1'b1);
      check("refresh", host.mem[16'h408], exp_q[0]);
      check("timer", host.mem[16'h3f5], 16'h5678);
   endtask
   task automatic multi_user();
      host.mem[16'h3f4] = 16'h0100;
      host.mem[16'h3f6] = 16'h0002;
      host.mem[16'h401] = 16'h0000;
      host.mem[16'h403] = 16'h8001;
      host.mem[16'h406] = 16'hbeef;
      servo_timer = 16'h0abc;
      run_pass(1'b1);
      check("var word", host.mem[16'h405], exp_q[1]);
      check("held var", host.mem[16'h406], 16'hbeef);
      check("ready set", host.mem[16'h401], 16'h8000);
      check("control", host.mem[16'h3f4], 16'h0100);
      check("timer", host.mem[16'h3f5], 16'h0abc);
      host.mem[16'h404] = 16'hcafe;
      servo_timer = 16'h0def;
      run_pass(1'b1);
      check("held var", host.mem[16'h404], 16'hcafe);
      check("timer", host.mem[16'h3f5], 16'h0def);
      host.mem[16'h403] = 16'h0001;
      run_pass(1'b1);
      check("long lo", host.mem[16'h406], exp_q[2]);
      check("long hi", host.mem[16'h409], exp_q[5]);
      check("ready set", host.mem[16'h403], 16'h8001);
      check("control", host.mem[16'h3f4], 16'h0100);
   endtask
   task automatic idle_cases();
      host.mem[16'h3f4] = 16'h0000;
      host.mem[16'h3f6] = 16'h0000;
      servo_timer = 16'h1111;
      run_pass(1'b0);
      check("timer", host.mem[16'h3f5], 16'h0def);
      host.mem[16'h3f6] = 16'h0001;
      host.mem[16'h401] = 16'h0000;
      en = 1'b0;
      run_pass(1'b0);
      en = 1'b1;
      run_pass(1'b1);
      check("data", host.mem[16'h402], exp_q[0]);
      check("timer", host.mem[16'h3f5], 16'h1111);
   endtask
   // Main sequence
   initial begin
      resetn = 1'b0;
      en = 1'b1;
      bg_cycle = 1'b0;
      slow = 1'b1;
      servo_timer = 16'h1234;
      seen_done = 1'b0;
      err_count = 0;
      n_compared = 0;
      step(8);
      resetn = 1'b1;
      step(1);
      single_user();
      multi_user();
      idle_cases();
      tally_and_finish();
   end
endmodule
